//--- logic/flash_wp_cfg.svh
// constants of the flash configuration and write protect block
`ifndef FLASH_WP_CFG_SVH
`define FLASH_WP_CFG_SVH

// command codes
`define OP_WREN        8'h06
`define OP_WRDI        8'h04
`define OP_WRSR        8'h01
`define OP_WRSR3       8'h11
`define OP_PP          8'h02
`define OP_SE          8'h20
`define OP_BE32        8'h52
`define OP_BE64        8'hd8
`define OP_CE1         8'hc7
`define OP_CE2         8'h60
`define OP_SCRP        8'h42
`define OP_SCRE        8'h44
`define OP_PDN         8'hb9
`define OP_REL         8'hab

// status register one fields
`define ST1_SRP0       7
`define ST1_SGR        6
`define ST1_TS         5
`define ST1_BP_HI      4
`define ST1_BP_LO      2
`define ST1_WMASK      8'hfc
`define ST1_RESET      8'h00

// status register two fields
`define ST2_CPL        6
`define ST2_LK_HI      5
`define ST2_LK_LO      3
`define ST2_QD         1
`define ST2_SRP1       0
`define ST2_WMASK      8'h43
`define ST2_LKMASK     8'h38
`define ST2_RESET      8'h00

// status register three fields
`define SR3_PSEL       7
`define SR3_DRV_HI     6
`define SR3_DRV_LO     5
`define SR3_HFQ        4
`define SR3_DY         0
`define SR3_WMASK      8'hf1
`define SR3_RESET      8'h10

// drive strength in percent
`define DRV_PCT_00     7'd50
`define DRV_PCT_01     7'd25
`define DRV_PCT_10     7'd75
`define DRV_PCT_11     7'd100

// dummy cycles
`define DUMMY_BB_LOW   4'h4
`define DUMMY_BB_HIGH  4'h8
`define DUMMY_EB_LOW   4'h6
`define DUMMY_EB_HIGH  4'ha

// array geometry
`define ARRAY_SIZE     23'h400000
`define ARRAY_TOP      22'h3fffff
`define BLOCK64_BYTES  23'h010000
`define SECTOR_BYTES   23'h001000
`define BLOCK32_BYTES  23'h008000
`define SECREG_SEL_HI  13
`define SECREG_SEL_LO  12

// synchroniser bit positions and reset levels
`define SY_TOG         3
`define SY_CS          2
`define SY_WP          1
`define SY_HOLD        0
`define SYNC_RESET     4'h7

// timing
`define CLK_PERIOD_NS  20
`define VSL_US         10
`define VSL_CYCLES     ((`VSL_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- logic/flash_wp_pkg.sv
// types of the flash configuration and write protect block
package flash_wp_pkg;

  typedef enum logic [3:0] {
    OPK_NONE          = 4'h0,
    OPK_PAGE_PROG     = 4'h1,
    OPK_SECTOR_ERASE  = 4'h2,
    OPK_BLOCK32_ERASE = 4'h3,
    OPK_BLOCK64_ERASE = 4'h4,
    OPK_CHIP_ERASE    = 4'h5,
    OPK_SCR_PROG      = 4'h6,
    OPK_SCR_ERASE     = 4'h7
  } op_kind_t;

  typedef struct packed {
    logic        valid;
    op_kind_t    kind;
    logic [23:0] addr;
  } op_req_t;

  typedef struct packed {
    logic       sgr;
    logic       ts;
    logic [2:0] bp;
    logic       cpl;
  } prot_bits_t;

  typedef struct packed {
    logic       wp_enabled;
    logic       hold_enabled;
    logic       reset_enabled;
    logic       quad_data_en;
    logic [1:0] drive_code;
    logic [6:0] drive_pct;
    logic       high_freq_mode;
    logic [3:0] dummy_bb;
    logic [3:0] dummy_eb;
  } pin_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_EXEC  = 2'b10,
    ST_SKIP  = 2'b11
  } cmd_state_t;

endpackage

//--- logic/link_frontend.sv
// serial clock side: bit toggle and held byte
`timescale 1ns/1ps
module link_frontend (
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_nrst,
  input  wire logic       i_di,
  output logic            o_bit_toggle,
  output logic [7:0]      o_byte_hold
);
  logic [6:0] shift;
  logic [2:0] bit_cnt;

  // ends with the frame: chip select high clears it, the clock may stop
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift <= 7'h00;
    end else begin
      shift <= {shift[5:0], i_di};
    end
  end

  // held for a whole byte so the system side can sample it unsynchronised
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_byte_hold <= 8'h00;
    end else if (bit_cnt == 3'h7) begin
      o_byte_hold <= {shift, i_di};
    end
  end

  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bit_toggle <= 1'b0;
    end else begin
      o_bit_toggle <= ~o_bit_toggle;
    end
  end
endmodule // link_frontend

//--- logic/protect_decoder.sv
// protected range decode and overlap test
`timescale 1ns/1ps
`include "flash_wp_cfg.svh"
module protect_decoder (
  input  wire flash_wp_pkg::prot_bits_t i_prot,
  input  wire logic [21:0]              i_start,
  input  wire logic [21:0]              i_end,
  output logic                          o_hit
);
  logic [22:0] size;
  logic [21:0] lo;
  logic [21:0] hi;
  logic        empty;

  always_comb begin
    size  = 23'h0;
    lo    = 22'h0;
    hi    = `ARRAY_TOP;
    empty = 1'b0;
    if (!i_prot.sgr) begin
      size = 23'(`BLOCK64_BYTES << (i_prot.bp - 3'h1)); // RULE19
    end else if (i_prot.bp[2]) begin
      size = `BLOCK32_BYTES; // RULE20
    end else begin
      size = 23'(`SECTOR_BYTES << (i_prot.bp - 3'h1)); // RULE20
    end
    if (i_prot.bp == 3'b000) begin
      empty = !i_prot.cpl; // RULE18
    end else if (i_prot.bp == 3'b111) begin
      empty = i_prot.cpl; // RULE18
    end else if (!i_prot.cpl) begin
      if (!i_prot.ts) begin
        lo = 22'(`ARRAY_SIZE - size); // RULE19
      end else begin
        hi = 22'(size - 23'h1); // RULE19
      end
    end else begin
      // swapped region, the remainder of the array
      if (!i_prot.ts) begin
        hi = 22'(`ARRAY_SIZE - size - 23'h1); // RULE23
      end else begin
        lo = 22'(size); // RULE23
      end
    end
  end

  assign o_hit = !empty && (i_start <= hi) && (i_end >= lo); // RULE24 RULE25
endmodule // protect_decoder

//--- logic/flash_config_write_protect.sv
// configuration bits and write protect logic of a serial nor flash
`timescale 1ns/1ps
`include "flash_wp_cfg.svh"
////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1: three one-time lock bits, status two 5:3
// RULE2: lock bit sticky, locked security register rejects writes
// RULE3: quad enable bit one of status two
// RULE4: quad enable turns protect pins into data
// RULE5: host never sets quad with tied pins
// RULE6: pin select: zero hold, one reset
// RULE7: hold or reset only while quad off
// RULE8: two-bit drive strength code to percent
// RULE9: high frequency mode bit, default one
// RULE10: dummy bit: bbh four or eight
// RULE11: dummy bit: ebh six or ten
// RULE12: non byte-aligned frames are discarded
// RULE13: no commands during power-up delay
// RULE14: write enable latch resets to zero
// RULE15: writes need write enable latch set
// RULE16: finished write clears write enable latch
// RULE17: deep power-down honours only release
// RULE18: code 000 none, 111 whole array
// RULE19: 64 kb block fractions, top or bottom
// RULE20: sector mode 4, 8, 16, 32 kb
// RULE21: protect pin with protect mode gates status writes
// RULE22: sector, top-bottom, block bits in status one
// RULE23: complement swaps protected and open regions
// RULE24: overlapping protected target ignores command
// RULE25: combinational protect check before operation start
////////////////////////////////////////////////////////////////////////////
module flash_config_write_protect #(
  parameter int unsigned POWER_UP_DELAY_CYCLES = `VSL_CYCLES
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_nrst,
  input  wire logic                    i_sclk,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_di,
  input  wire logic                    i_wp_n,
  input  wire logic                    i_hold_rst_n,
  input  wire logic                    i_op_done,
  output flash_wp_pkg::op_req_t        o_op,
  output logic                         o_busy,
  output logic                         o_write_enable_latch,
  output logic                         o_deep_power_down,
  output logic                         o_cmd_ready,
  output logic                         o_cmd_rejected,
  output logic [7:0]                   o_status_reg_one,
  output logic [7:0]                   o_status_reg_two,
  output logic [7:0]                   o_status_reg_three,
  output flash_wp_pkg::pin_cfg_t       o_pin_cfg,
  output logic                         o_hold_active,
  output logic                         o_pin_reset_active
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic flash_wp_pkg::op_kind_t classify(input logic [7:0] op);
    flash_wp_pkg::op_kind_t k;
    k = flash_wp_pkg::OPK_NONE;
    case (op)
      `OP_PP:   k = flash_wp_pkg::OPK_PAGE_PROG;
      `OP_SE:   k = flash_wp_pkg::OPK_SECTOR_ERASE;
      `OP_BE32: k = flash_wp_pkg::OPK_BLOCK32_ERASE;
      `OP_BE64: k = flash_wp_pkg::OPK_BLOCK64_ERASE;
      `OP_CE1:  k = flash_wp_pkg::OPK_CHIP_ERASE;
      `OP_CE2:  k = flash_wp_pkg::OPK_CHIP_ERASE;
      `OP_SCRP: k = flash_wp_pkg::OPK_SCR_PROG;
      `OP_SCRE: k = flash_wp_pkg::OPK_SCR_ERASE;
      default:  k = flash_wp_pkg::OPK_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [6:0] drive_pct(input logic [1:0] code);
    logic [6:0] p;
    p = `DRV_PCT_11;
    case (code)
      2'b00:   p = `DRV_PCT_00;
      2'b01:   p = `DRV_PCT_01;
      2'b10:   p = `DRV_PCT_10;
      default: p = `DRV_PCT_11;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link side and crossings

  logic                       link_toggle;
  logic [7:0]                 link_byte;
  logic [3:0]                 sync_meta;
  logic [3:0]                 sync_q;
  logic [3:0]                 sync_in;
  logic                       tog_d;
  logic                       cs_d;
  logic                       bit_edge;
  logic                       cs_fall;
  logic                       cs_rise;

  link_frontend u_link (
    .i_sclk       (i_sclk),
    .i_cs_n       (i_cs_n),
    .i_nrst       (i_nrst),
    .i_di         (i_di),
    .o_bit_toggle (link_toggle),
    .o_byte_hold  (link_byte)
  );

  assign sync_in = {link_toggle, i_cs_n, i_wp_n, i_hold_rst_n};

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_meta <= `SYNC_RESET;
      sync_q    <= `SYNC_RESET;
    end else begin
      sync_meta <= sync_in;
      sync_q    <= sync_meta;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tog_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      tog_d <= sync_q[`SY_TOG];
      cs_d  <= sync_q[`SY_CS];
    end
  end

  assign bit_edge = sync_q[`SY_TOG] ^ tog_d;
  assign cs_fall  = cs_d & ~sync_q[`SY_CS];
  assign cs_rise  = ~cs_d & sync_q[`SY_CS];

  ////////////////////////////////////////////////////////////////////////
  // pin roles

  logic qd;
  logic hold_fn;
  logic reset_fn;
  logic pin_reset;
  logic wp_level;

  assign qd        = o_status_reg_two[`ST2_QD];
  assign hold_fn   = !qd && !o_status_reg_three[`SR3_PSEL]; // RULE6 RULE7
  assign reset_fn  = !qd && o_status_reg_three[`SR3_PSEL]; // RULE6 RULE7
  assign pin_reset = reset_fn && !sync_q[`SY_HOLD];
  // with quad on the protect pin carries data and reads as released
  assign wp_level  = qd ? 1'b1 : sync_q[`SY_WP]; // RULE4

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hold_active      <= 1'b0;
      o_pin_reset_active <= 1'b0;
    end else begin
      o_hold_active      <= hold_fn && !sync_q[`SY_HOLD]; // RULE7
      o_pin_reset_active <= pin_reset; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up command delay

  logic [15:0] vsl_cnt;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vsl_cnt     <= 16'h0000;
      o_cmd_ready <= 1'b0;
    end else if (!o_cmd_ready) begin
      vsl_cnt <= vsl_cnt + 16'h0001;
      if (vsl_cnt == 16'(POWER_UP_DELAY_CYCLES - 1)) begin
        o_cmd_ready <= 1'b1; // RULE13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame capture

  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  data_one;
  logic [7:0]  data_two;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      opcode   <= 8'h00;
      addr     <= 24'h000000;
      data_one <= 8'h00;
      data_two <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (bit_edge) begin
      bit_cnt <= bit_cnt + 3'h1; // RULE12
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        case (byte_cnt)
          3'h0: opcode <= link_byte;
          3'h1: begin
            addr[23:16] <= link_byte;
            data_one    <= link_byte;
          end
          3'h2: begin
            addr[15:8] <= link_byte;
            data_two   <= link_byte;
          end
          3'h3: addr[7:0] <= link_byte;
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command state

  flash_wp_pkg::cmd_state_t state;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= flash_wp_pkg::ST_IDLE;
    end else if (pin_reset) begin
      state <= flash_wp_pkg::ST_IDLE;
    end else begin
      case (state)
        flash_wp_pkg::ST_IDLE: begin
          if (cs_fall) begin
            state <= o_cmd_ready ? flash_wp_pkg::ST_FRAME
                                 : flash_wp_pkg::ST_SKIP; // RULE13
          end
        end
        flash_wp_pkg::ST_FRAME: begin
          if (cs_rise) begin
            state <= flash_wp_pkg::ST_EXEC;
          end
        end
        flash_wp_pkg::ST_EXEC: state <= flash_wp_pkg::ST_IDLE;
        default: begin
          if (cs_rise) begin
            state <= flash_wp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decision at the end of a frame

  flash_wp_pkg::op_kind_t   kind;
  flash_wp_pkg::prot_bits_t prot;
  logic [21:0]              tgt_start;
  logic [21:0]              tgt_end;
  logic                     prot_hit;
  logic                     scr_locked;
  logic                     sr_writable;
  logic                     aligned;
  logic                     do_wren;
  logic                     do_wrdi;
  logic                     do_sr12;
  logic                     do_sr3;
  logic                     do_op;
  logic                     do_pdn;
  logic                     do_rel;
  logic                     reject;

  assign kind = classify(opcode);
  assign prot = '{sgr: o_status_reg_one[`ST1_SGR],
                  ts:  o_status_reg_one[`ST1_TS],
                  bp:  o_status_reg_one[`ST1_BP_HI:`ST1_BP_LO],
                  cpl: o_status_reg_two[`ST2_CPL]}; // RULE22

  always_comb begin
    tgt_start = addr[21:0];
    tgt_end   = addr[21:0];
    case (kind)
      flash_wp_pkg::OPK_PAGE_PROG:     tgt_end = {addr[21:8], 8'hff};
      flash_wp_pkg::OPK_SECTOR_ERASE: begin
        tgt_start = {addr[21:12], 12'h000};
        tgt_end   = {addr[21:12], 12'hfff};
      end
      flash_wp_pkg::OPK_BLOCK32_ERASE: begin
        tgt_start = {addr[21:15], 15'h0000};
        tgt_end   = {addr[21:15], 15'h7fff};
      end
      flash_wp_pkg::OPK_BLOCK64_ERASE: begin
        tgt_start = {addr[21:16], 16'h0000};
        tgt_end   = {addr[21:16], 16'hffff};
      end
      flash_wp_pkg::OPK_CHIP_ERASE: begin
        tgt_start = 22'h000000;
        tgt_end   = `ARRAY_TOP;
      end
      default: begin
      end
    endcase
  end

  protect_decoder u_prot (
    .i_prot  (prot),
    .i_start (tgt_start),
    .i_end   (tgt_end),
    .o_hit   (prot_hit)
  );

  always_comb begin
    case (addr[`SECREG_SEL_HI:`SECREG_SEL_LO])
      2'b01:   scr_locked = o_status_reg_two[`ST2_LK_LO]; // RULE2
      2'b10:   scr_locked = o_status_reg_two[`ST2_LK_LO + 1]; // RULE2
      2'b11:   scr_locked = o_status_reg_two[`ST2_LK_HI]; // RULE2
      default: scr_locked = 1'b1;
    endcase
  end

  // lock-down and one-time modes never accept a status write here
  assign sr_writable = !o_status_reg_two[`ST2_SRP1] &&
                       (!o_status_reg_one[`ST1_SRP0] || wp_level); // RULE21
  assign aligned = (bit_cnt == 3'h0) && (byte_cnt != 3'h0);

  always_comb begin
    do_wren = 1'b0;
    do_wrdi = 1'b0;
    do_sr12 = 1'b0;
    do_sr3  = 1'b0;
    do_op   = 1'b0;
    do_pdn  = 1'b0;
    do_rel  = 1'b0;
    reject  = 1'b0;
    if (state == flash_wp_pkg::ST_EXEC) begin
      if (!aligned) begin
        reject = 1'b1; // RULE12
      end else if (o_busy) begin
        reject = 1'b1;
      end else if (o_deep_power_down) begin
        do_rel = (opcode == `OP_REL); // RULE17
        reject = (opcode != `OP_REL); // RULE17
      end else begin
        case (opcode)
          `OP_WREN: do_wren = 1'b1;
          `OP_WRDI: do_wrdi = 1'b1;
          `OP_PDN:  do_pdn  = 1'b1;
          `OP_WRSR: begin
            do_sr12 = o_write_enable_latch && sr_writable &&
                      (byte_cnt >= 3'h2); // RULE15 RULE21
            reject  = !do_sr12;
          end
          `OP_WRSR3: begin
            do_sr3 = o_write_enable_latch && sr_writable &&
                     (byte_cnt >= 3'h2); // RULE15 RULE21
            reject = !do_sr3;
          end
          default: begin
            if (kind == flash_wp_pkg::OPK_SCR_PROG ||
                kind == flash_wp_pkg::OPK_SCR_ERASE) begin
              do_op = o_write_enable_latch && (byte_cnt >= 3'h4) &&
                      !scr_locked; // RULE2 RULE15
              reject = !do_op;
            end else if (kind != flash_wp_pkg::OPK_NONE) begin
              do_op = o_write_enable_latch && !prot_hit &&
                      ((byte_cnt >= 3'h4) ||
                       (kind == flash_wp_pkg::OPK_CHIP_ERASE)); // RULE15 RULE24
              reject = !do_op;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write enable latch, power-down, busy

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_write_enable_latch <= 1'b0; // RULE14
    end else if (pin_reset) begin
      o_write_enable_latch <= 1'b0;
    end else if (do_wren) begin
      o_write_enable_latch <= 1'b1;
    end else if (do_wrdi || do_sr12 || do_sr3 || i_op_done) begin
      o_write_enable_latch <= 1'b0; // RULE16
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_deep_power_down <= 1'b0;
    end else if (do_rel || pin_reset) begin
      o_deep_power_down <= 1'b0; // RULE17
    end else if (do_pdn) begin
      o_deep_power_down <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else if (do_op) begin
      o_busy <= 1'b1;
    end else if (i_op_done) begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_op           <= '0;
      o_cmd_rejected <= 1'b0;
    end else begin
      o_op.valid     <= do_op; // RULE25
      o_cmd_rejected <= reject;
      if (do_op) begin
        o_op.kind <= kind;
        o_op.addr <= addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status registers

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status_reg_one <= `ST1_RESET; // RULE22
      o_status_reg_two <= `ST2_RESET; // RULE1 RULE3
    end else if (do_sr12) begin
      o_status_reg_one <= (o_status_reg_one & ~`ST1_WMASK) |
                          (data_one & `ST1_WMASK); // RULE22
      if (byte_cnt >= 3'h3) begin
        // lock bits only ever gain ones
        o_status_reg_two <= (o_status_reg_two &
                             ~(`ST2_WMASK | `ST2_LKMASK)) |
                            (data_two & `ST2_WMASK) |
                            ((o_status_reg_two | data_two) &
                             `ST2_LKMASK); // RULE1 RULE2 RULE3
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status_reg_three <= `SR3_RESET; // RULE9
    end else if (do_sr3) begin
      o_status_reg_three <= (o_status_reg_three & ~`SR3_WMASK) |
                            (data_one & `SR3_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin and read configuration

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_cfg <= '0;
    end else begin
      o_pin_cfg.wp_enabled     <= !qd; // RULE3
      o_pin_cfg.hold_enabled   <= hold_fn; // RULE6
      o_pin_cfg.reset_enabled  <= reset_fn; // RULE6
      o_pin_cfg.quad_data_en   <= qd; // RULE4
      o_pin_cfg.drive_code     <=
        o_status_reg_three[`SR3_DRV_HI:`SR3_DRV_LO];
      o_pin_cfg.drive_pct      <=
        drive_pct(o_status_reg_three[`SR3_DRV_HI:`SR3_DRV_LO]); // RULE8
      o_pin_cfg.high_freq_mode <= o_status_reg_three[`SR3_HFQ]; // RULE9
      o_pin_cfg.dummy_bb       <= o_status_reg_three[`SR3_DY] ?
                                  `DUMMY_BB_HIGH : `DUMMY_BB_LOW; // RULE10
      o_pin_cfg.dummy_eb       <= o_status_reg_three[`SR3_DY] ?
                                  `DUMMY_EB_HIGH : `DUMMY_EB_LOW; // RULE11
    end
  end

endmodule // flash_config_write_protect

//--- verification/flash_wp_properties.sv
// port assertions for the flash write protect block
`timescale 1ns/1ps
module flash_wp_properties #(
  parameter int unsigned POWER_UP_DELAY_CYCLES = 500
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_op_done,
  input wire flash_wp_pkg::op_req_t o_op,
  input wire logic o_busy,
  input wire logic o_write_enable_latch,
  input wire logic o_cmd_ready,
  input wire logic [7:0] o_status_reg_two,
  input wire logic [7:0] o_status_reg_three,
  input wire flash_wp_pkg::pin_cfg_t o_pin_cfg
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  localparam logic [6:0] PCT [4] = '{7'd50, 7'd25, 7'd75, 7'd100};
  logic [15:0] up;
  // pin_cfg trails status by one edge, so the first edge is skipped
  always_ff @(posedge i_sys_clk or negedge i_nrst)
    if (!i_nrst) up <= 16'h0;
    else if (up != 16'hffff) up <= up + 16'h1;
  sequence s_done; i_op_done && o_busy; endsequence
  property p_ready; up < POWER_UP_DELAY_CYCLES |-> !o_cmd_ready; endproperty
  a_ready: assert property (p_ready) else $error("early ready");
  property p_op; o_op.valid |-> o_write_enable_latch ##[0:1] o_busy;
  endproperty
  a_op: assert property (p_op) else $error("op start");
  property p_lock;
    (8'h38 & $past(o_status_reg_two) & ~o_status_reg_two) == 8'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_wen; s_done |=> !o_busy && !o_write_enable_latch; endproperty
  a_wen: assert property (p_wen) else $error("latch kept");
  property p_quad;
    up != 0 |-> o_pin_cfg.quad_data_en == $past(o_status_reg_two[1]);
  endproperty
  a_quad: assert property (p_quad) else $error("quad");
  property p_hold; up != 0 |-> o_pin_cfg.hold_enabled ==
    $past(!o_status_reg_two[1] && !o_status_reg_three[7]); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_drv;
    up != 0 |-> o_pin_cfg.drive_pct == PCT[$past(o_status_reg_three[6:5])];
  endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_cfg; up != 0 |-> o_pin_cfg.high_freq_mode ==
    $past(o_status_reg_three[4]) && o_pin_cfg.dummy_eb ==
    ($past(o_status_reg_three[0]) ? 4'ha : 4'h6) && o_pin_cfg.dummy_bb
    == ($past(o_status_reg_three[0]) ? 4'h8 : 4'h4); endproperty
  a_cfg: assert property (p_cfg) else $error("mode");
endmodule // flash_wp_properties
bind flash_config_write_protect flash_wp_properties #(
  .POWER_UP_DELAY_CYCLES(POWER_UP_DELAY_CYCLES)
) flash_wp_properties_inst (.i_sys_clk, .i_nrst, .i_op_done, .o_op,
  .o_busy, .o_write_enable_latch, .o_cmd_ready, .o_status_reg_two,
  .o_status_reg_three, .o_pin_cfg);

//--- verification/spi_host.sv
// host controller model: mode 0 frames, msb first
`timescale 1ns/1ps
module spi_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_di
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di = 1'b0;
  end
  // clock parked low; released data shows the inverse, never the last bit
  task automatic frame(input logic [39:0] d, input int n);
    o_cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      o_di = d[39-k];
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    o_di = ~o_di;
    #250;
  endtask
  // quad mode never set: protect pins are tied high here
endmodule // spi_host

//--- verification/tb_top.sv
// self-checking bench of the flash write protect block
`timescale 1ns/1ps
module tb_top;
  logic i_sys_clk, i_nrst, i_sclk, i_cs_n, i_di, i_wp_n, i_hold_rst_n;
  logic i_op_done, o_busy, o_write_enable_latch, o_deep_power_down;
  logic o_cmd_ready, o_cmd_rejected, o_hold_active, o_pin_reset_active;
  logic [7:0] o_status_reg_one, o_status_reg_two, o_status_reg_three, rnd;
  flash_wp_pkg::op_req_t o_op;
  logic [28:0] exp_q [$];
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 38793;
  localparam logic [3:0] SE = flash_wp_pkg::OPK_SECTOR_ERASE;
  flash_config_write_protect #(.POWER_UP_DELAY_CYCLES(8))
    flash_config_write_protect_inst (.o_pin_cfg(), .*);
  spi_host spi_host_inst (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_di(i_di));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input string n, input logic [28:0] e, s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a refusal is noted as the top bit alone
  always @(negedge i_sys_clk)
    if (o_op.valid === 1'b1 || o_cmd_rejected === 1'b1)
      check("result", exp_q.size() ? exp_q.pop_front() : 29'h0,
            o_cmd_rejected ? 29'h10000000 : {1'b0, o_op.kind, o_op.addr});
  task automatic send(input logic [39:0] d, input int n, input bit p = 0,
                      input logic [28:0] e = 29'h10000000);
    if (p) exp_q.push_back(e);
    spi_host_inst.frame(d, n);
  endtask
  task automatic done;
    @(posedge i_sys_clk) #1 i_op_done = 1'b1;
    @(posedge i_sys_clk) #1 i_op_done = 1'b0;
    #41;
  endtask
  initial begin
    {i_nrst, i_wp_n, i_hold_rst_n, i_op_done} = 4'b0110;
    repeat (5) @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    send({8'h06, 32'h0}, 8);
    check("wen", 0, o_write_enable_latch);
    send({8'h20, 32'h0}, 32, 1);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h123000, 8'h0}, 32, 1, {1'b0, SE, 24'h123000});
    done;
    check("wen", 0, o_write_enable_latch);
    send({8'h06, 32'h0}, 8);
    send({8'h01, 8'h04, 8'h08, 16'h0}, 24);
    check("sr1", 8'h04, o_status_reg_one);
    check("sr2", 8'h08, o_status_reg_two);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h3ff000, 8'h0}, 32, 1);
    send({8'h20, 24'h3ef000, 8'h0}, 32, 1, {1'b0, SE, 24'h3ef000});
    done;
    send({8'h06, 32'h0}, 8);
    send({8'h44, 24'h001000, 8'h0}, 32, 1);
    send({8'h01, 8'h04, 8'h40, 16'h0}, 24);
    check("sr2", 8'h48, o_status_reg_two);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 32'h0}, 31, 1);
    send({8'h20, 32'h0}, 32, 1);
    send({8'hb9, 32'h0}, 8);
    send({8'h06, 32'h0}, 8, 1);
    send({8'hab, 32'h0}, 8);
    check("pdn", 0, o_deep_power_down);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      rnd[6:5] = i[1:0];
      send({8'h06, 32'h0}, 8);
      send({8'h11, rnd, 24'h0}, 16);
      check("sr3", rnd & 8'hf1, o_status_reg_three);
    end
    check("left", 0, exp_q.size());
    check("pins", 0, {o_hold_active, o_pin_reset_active});
    finish_test;
  end
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
endmodule // tb_top
